// ===== sim/dmcp_host.sv
`timescale 1ns/10ps
`default_nettype none
module dmcp_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic shift_clk_o,
	output var  logic serial_o,
	output var  logic select_n_o,
	output var  logic scl_o,
	output var  logic sda_o
);
	initial {shift_clk_o, serial_o, select_n_o, scl_o, sda_o} = 5'h07;
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// ----
	// Three-wire word, first n bits
	// ----
	task automatic word(input logic [15:0] v, input int n);
		int i;
		select_n_o <= 1'b0;
		w(4);
		for (i = 15; i > 15 - n; i--) begin
			serial_o <= v[i];
			w(4);
			shift_clk_o <= 1'b1;
			w(4);
			shift_clk_o <= 1'b0;
		end
		w(4);
		select_n_o <= 1'b1;
		serial_o <= ~serial_o;
		w(8);
	endtask
	task automatic edge_cond(input logic a, b, c);
		w(2);
		sda_o <= a;
		w(8);
		scl_o <= 1'b1;
		w(8);
		sda_o <= b;
		w(8);
		scl_o <= c;
	endtask
	task automatic xfer(input logic [8:0] v, output logic [8:0] r);
		int i;
		for (i = 8; i >= 0; i--) begin
			w(2);
			sda_o <= v[i];
			w(6);
			scl_o <= 1'b1;
			w(4);
			r[i] = sda_i;
			w(4);
			scl_o <= 1'b0;
		end
	endtask
endmodule // dmcp_host
`default_nettype wire

// ===== sim/dmcp_mode_ctl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dmcp_chk (
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       ctl_select_n_i,
	input wire logic       mute_pin_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       mode_valid_o,
	input wire logic [1:0] ctl_mode_o,
	input wire logic       hw_wide_os_o,
	input wire logic       hw_mute_o,
	input wire logic       reg_wr_o,
	input wire logic [6:0] reg_wr_index_o
);
	wire hw = mode_valid_o && (ctl_mode_o[1] != ctl_mode_o[0]);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wr_one_cycle_a: assert property (reg_wr_o |=> !reg_wr_o[*4])
		else $error("write pulse too long");
	wr_serial_a: assert property (reg_wr_o |-> mode_valid_o &&
		(ctl_mode_o == 2'h3 || ctl_mode_o == 2'h0)) else $error("write in hw");
	wr_range_a: assert property (reg_wr_o |-> reg_wr_index_o <= 7'h13)
		else $error("undefined index written");
	spi_latch_a: assert property (reg_wr_o && ctl_mode_o == 2'h3 |->
		$past(ctl_select_n_i, 3) && !$past(ctl_select_n_i, 7))
		else $error("write without select rise");
	ack_mode_a: assert property (!sda_oe_o |-> !sda_o &&
		mode_valid_o && ctl_mode_o == 2'h0) else $error("bad sda drive");
	mode_hold_a: assert property (mode_valid_o |=>
		mode_valid_o && $stable(ctl_mode_o)) else $error("mode changed");
	wide_os_a: assert property (mode_valid_o[*3] |->
		hw_wide_os_o == (ctl_mode_o == 2'h2)) else $error("bad oversampling");
	mute_follow_a: assert property ((hw && $stable(mute_pin_i))[*4] |->
		hw_mute_o == mute_pin_i) else $error("mute not following pin");
	cover property (reg_wr_o && ctl_mode_o == 2'h3);
	cover property (reg_wr_o && ctl_mode_o == 2'h0);
	cover property (hw && hw_mute_o);
endmodule // dmcp_chk
bind dmcp_mode_ctl dmcp_chk u_chk (.clk_i, .resetn_i, .ctl_select_n_i,
	.mute_pin_i, .sda_o, .sda_oe_o, .mode_valid_o, .ctl_mode_o,
	.hw_wide_os_o, .hw_mute_o, .reg_wr_o, .reg_wr_index_o);
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        strap = 1'b0;
	logic        tied = 1'b0;
	logic        adr = 1'b0;
	logic  [3:0] pins = 4'h0;
	logic  [8:0] r;
	logic [15:0] v;
	wire         mc, md, ms_n, scl, h_sda, d_sda, d_oe, valid, wr;
	wire         wide, dmp, mute;
	wire   [1:0] mode, fmt;
	wire   [6:0] wi, ri;
	wire   [7:0] wd;
	wire         sda = h_sda & (d_oe | d_sda);
	wire   [7:0] rd;
	int          err_count = 0;
	int          checks = 0;
	int          nw = 0;
	int          i;
	always #12.5 clk_i = ~clk_i;
	always @(negedge clk_i) nw += wr;
	dmcp_host host (.clk_i(clk_i), .sda_i(sda), .shift_clk_o(mc),
		.serial_o(md), .select_n_o(ms_n), .scl_o(scl), .sda_o(h_sda));
	dmcp_mode_ctl uut (.clk_i(clk_i), .resetn_i(resetn_i),
		.control_mode_strap_i(strap), .strap_tied_i(tied),
		.format_sel_lo_i(pins[2]), .format_sel_hi_i(pins[3]),
		.deemph_enable_pin_i(pins[1]), .mute_pin_i(pins[0]),
		.ctl_serial_in_i(md), .ctl_shift_clock_i(mc), .ctl_select_n_i(ms_n),
		.scl_i(scl), .sda_i(sda), .addr_sel_i(adr), .reg_rd_data_i(rd),
		.sda_o(d_sda), .sda_oe_o(d_oe), .mode_valid_o(valid),
		.ctl_mode_o(mode), .hw_wide_os_o(wide), .hw_format_o(fmt),
		.hw_deemph_o(dmp), .hw_mute_o(mute), .reg_wr_o(wr),
		.reg_wr_index_o(wi), .reg_wr_data_o(wd), .reg_rd_index_o(ri));
	task automatic chk(input logic [15:0] g, e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_cnt(input logic [7:0] g, e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	function automatic logic [2:0] exp_mode(input logic s, t);
		exp_mode = {1'b1, s, t ? s : ~s};
	endfunction
	function automatic logic [4:0] exp_hw(input logic w_os,
		input logic [3:0] p);
		logic [1:0] f;
		case (p[3:2])
		2'b00:   f = 2'h0;
		2'b01:   f = 2'h1;
		2'b10:   f = 2'h2;
		default: f = 2'h3;
		endcase
		exp_hw = {w_os, f, p[1], p[0]};
	endfunction
	function automatic logic [7:0] reg_image(input logic [6:0] idx);
		reg_image = {1'b0, idx} ^ 8'h5A;
	endfunction
	assign rd = reg_image(ri);
	task automatic print_verdict;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic rst(input logic s, t);
		resetn_i <= 1'b0;
		strap <= s;
		tied <= t;
		host.w(2);
		resetn_i <= 1'b1;
		host.w(6);
		strap <= ~s;
		host.w(6);
		chk({valid, mode}, exp_mode(s, t));
		if (t) chk({wide, fmt, dmp, mute}, 5'h00);
	endtask
	task automatic i2c(input logic [6:0] a, input logic [7:0] x, d,
		input logic k, rw);
		host.edge_cond(1'b1, 1'b0, 1'b0);
		host.xfer({a, 2'b01}, r);
		chk(r[0], k);
		host.xfer({x, 1'b1}, r);
		chk(r[0], k);
		if (rw) begin
			host.edge_cond(1'b1, 1'b0, 1'b0);
			host.xfer({a, 2'b11}, r);
			chk(r[0], k);
			host.xfer(9'h1FF, r);
			chk({ri, r[8:1]}, {x[6:0], reg_image(x[6:0])});
		end else begin
			host.xfer({d, 1'b1}, r);
			chk(r[0], k);
		end
		host.edge_cond(1'b0, 1'b1, 1'b1);
	endtask
	initial begin
		#2000000;
		err_count++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'h405bb337));
		for (i = 0; i < 32; i++) begin
			if (i % 16 == 0) rst(i[4], 1'b0);
			pins <= i[3:0] ^ 4'($urandom);
			host.w(6);
			chk({wide, fmt, dmp, mute}, exp_hw(i[4], pins));
		end
		rst(1'b1, 1'b1);
		for (i = 0; i < 5; i++) begin
			v = {1'b0, 7'($urandom_range(1, 14)), 8'($urandom)};
			if (i == 4) v = 16'h1355;
			host.word(v, 16);
			chk({1'b0, wi, wd}, v);
		end
		host.word(16'h1466, 16);
		host.word(16'h8166, 16);
		host.word(16'h0266, 15);
		chk_cnt(nw[7:0], 8'h05);
		chk({1'b0, wi, wd}, 16'h1355);
		rst(1'b0, 1'b1);
		adr <= 1'($urandom);
		host.word(16'h0366, 16);
		i2c({6'h26, adr}, 8'h07, 8'hC3, 1'b0, 1'b0);
		i2c({6'h26, ~adr}, 8'h05, 8'h11, 1'b1, 1'b0);
		i2c({6'h26, adr}, 8'h14, 8'h22, 1'b0, 1'b0);
		chk_cnt(nw[7:0], 8'h06);
		chk({1'b0, wi, wd}, 16'h07C3);
		i2c({6'h26, adr}, 8'($urandom_range(1, 19)), 8'h00, 1'b0, 1'b1);
		chk_cnt(nw[7:0], 8'h06);
		print_verdict;
	end
endmodule // tb
`default_nettype wire

// ===== verilog/dmcp_defs.vh
`ifndef DMCP_DEFS_VH
`define DMCP_DEFS_VH

// ----------------------------------------
// Interface mode from strap
// ----------------------------------------
`define DMCP_MODE_I2C      2'h0
`define DMCP_MODE_HW_NAR   2'h1
`define DMCP_MODE_HW_WIDE  2'h2
`define DMCP_MODE_SPI      2'h3

// ----------------------------------------
// Audio format codes
// ----------------------------------------
`define DMCP_FMT_RJ24      2'h0
`define DMCP_FMT_I2S       2'h1
`define DMCP_FMT_LJ        2'h2
`define DMCP_FMT_TDM       2'h3

// ----------------------------------------
// Control word and register space
// ----------------------------------------
`define DMCP_WORD_BITS     5'h10
`define DMCP_WORD_MSB      15
`define DMCP_REG_LAST      7'h13
`define DMCP_SLV_ADDR_HI   6'h26
`define DMCP_SETTLE_LAST   2'h3
`define DMCP_PIN_IDLE      12'h00E

`endif

// ===== verilog/dmcp_mode_ctl.v
`timescale 1ns/10ps
`default_nettype none
`include "dmcp_defs.vh"

module dmcp_mode_ctl (
	input  wire       clk_i,
	input  wire       resetn_i,
	input  wire       control_mode_strap_i,
	input  wire       strap_tied_i,
	input  wire       format_sel_lo_i,
	input  wire       format_sel_hi_i,
	input  wire       deemph_enable_pin_i,
	input  wire       mute_pin_i,
	input  wire       ctl_serial_in_i,
	input  wire       ctl_shift_clock_i,
	input  wire       ctl_select_n_i,
	input  wire       scl_i,
	input  wire       sda_i,
	input  wire       addr_sel_i,
	input  wire [7:0] reg_rd_data_i,
	output wire       sda_o,
	output wire       sda_oe_o,
	output reg        mode_valid_o,
	output reg  [1:0] ctl_mode_o,
	output reg        hw_wide_os_o,
	output reg  [1:0] hw_format_o,
	output reg        hw_deemph_o,
	output reg        hw_mute_o,
	output reg        reg_wr_o,
	output reg  [6:0] reg_wr_index_o,
	output reg  [7:0] reg_wr_data_o,
	output reg  [6:0] reg_rd_index_o
);

	// ----------------------------------------
	// Two-wire slave states
	// ----------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RX   = 3'h1;
	localparam [2:0] ST_ACK  = 3'h2;
	localparam [2:0] ST_TX   = 3'h3;
	localparam [2:0] ST_MACK = 3'h4;

	localparam [1:0] PH_ADDR = 2'h0;
	localparam [1:0] PH_REG  = 2'h1;
	localparam [1:0] PH_DATA = 2'h2;

	localparam integer NPIN = 12;

	function index_defined;
		input [6:0] idx;
		begin
			index_defined = (idx <= `DMCP_REG_LAST);
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg  [NPIN-1:0] pin_meta;
	reg  [NPIN-1:0] pin_sync;
	wire [NPIN-1:0] pin_raw;

	assign pin_raw = {control_mode_strap_i, strap_tied_i,
		format_sel_hi_i, format_sel_lo_i, deemph_enable_pin_i,
		mute_pin_i, ctl_serial_in_i, ctl_shift_clock_i,
		ctl_select_n_i, scl_i, sda_i, addr_sel_i};

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_meta <= `DMCP_PIN_IDLE;
			pin_sync <= `DMCP_PIN_IDLE;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire s_strap  = pin_sync[11];
	wire s_tied   = pin_sync[10];
	wire s_fmt_hi = pin_sync[9];
	wire s_fmt_lo = pin_sync[8];
	wire s_deemph = pin_sync[7];
	wire s_mute   = pin_sync[6];
	wire s_mdata  = pin_sync[5];
	wire s_mclk   = pin_sync[4];
	wire s_control_mode_strap_n = pin_sync[3];
	wire s_scl    = pin_sync[2];
	wire s_sda    = pin_sync[1];
	wire s_adr    = pin_sync[0];

	// ----------------------------------------
	// Strap capture after reset release
	// ----------------------------------------
	reg [1:0] settle;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			settle       <= 2'h0;
			mode_valid_o <= 1'b0;
			ctl_mode_o   <= `DMCP_MODE_I2C;
		end else if (!mode_valid_o) begin
			settle <= settle + 2'h1;
			if (settle == `DMCP_SETTLE_LAST) begin
				mode_valid_o <= 1'b1;
				case ({s_tied, s_strap})
				2'b10:   ctl_mode_o <= `DMCP_MODE_I2C;
				2'b11:   ctl_mode_o <= `DMCP_MODE_SPI;
				2'b01:   ctl_mode_o <= `DMCP_MODE_HW_WIDE;
				default: ctl_mode_o <= `DMCP_MODE_HW_NAR;
				endcase
			end
		end
	end

	wire hw_mode  = mode_valid_o &&
		(ctl_mode_o == `DMCP_MODE_HW_NAR ||
		ctl_mode_o == `DMCP_MODE_HW_WIDE);
	wire spi_mode = mode_valid_o && ctl_mode_o == `DMCP_MODE_SPI;
	wire i2c_mode = mode_valid_o && ctl_mode_o == `DMCP_MODE_I2C;

	// ----------------------------------------
	// Parallel hardware control
	// ----------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hw_wide_os_o <= 1'b0;
			hw_format_o  <= `DMCP_FMT_RJ24;
			hw_deemph_o  <= 1'b0;
			hw_mute_o    <= 1'b0;
		end else begin
			hw_wide_os_o <= hw_mode &&
				ctl_mode_o == `DMCP_MODE_HW_WIDE;
			if (!hw_mode)
				hw_format_o <= `DMCP_FMT_RJ24;
			else begin
				case ({s_fmt_hi, s_fmt_lo})
				2'b00:   hw_format_o <= `DMCP_FMT_RJ24;
				2'b01:   hw_format_o <= `DMCP_FMT_I2S;
				2'b10:   hw_format_o <= `DMCP_FMT_LJ;
				default: hw_format_o <= `DMCP_FMT_TDM;
				endcase
			end
			hw_deemph_o <= hw_mode && s_deemph;
			hw_mute_o   <= hw_mode && s_mute;
		end
	end

	// ----------------------------------------
	// Three-wire write port
	// ----------------------------------------
	reg        mclk_d;
	reg        control_mode_strap_d;
	reg [15:0] spi_sr;
	reg [4:0]  spi_cnt;
	reg        spi_wr;

	wire mclk_rise = s_mclk && !mclk_d;
	wire control_mode_strap_rise = s_control_mode_strap_n && !control_mode_strap_d;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mclk_d  <= 1'b0;
			control_mode_strap_d  <= 1'b1;
			spi_sr  <= 16'h0000;
			spi_cnt <= 5'h00;
			spi_wr  <= 1'b0;
		end else begin
			mclk_d <= s_mclk;
			control_mode_strap_d <= s_control_mode_strap_n;
			spi_wr <= 1'b0;
			if (!spi_mode || s_control_mode_strap_n) begin
				spi_cnt <= 5'h00;
			end else if (mclk_rise) begin
				spi_sr <= {spi_sr[14:0], s_mdata};
				if (spi_cnt != 5'h1F)
					spi_cnt <= spi_cnt + 5'h01;
			end
			if (spi_mode && control_mode_strap_rise && spi_cnt == `DMCP_WORD_BITS &&
				!spi_sr[`DMCP_WORD_MSB] &&
				index_defined(spi_sr[14:8]))
				spi_wr <= 1'b1;
		end
	end

	// ----------------------------------------
	// Two-wire slave port
	// ----------------------------------------
	reg       scl_d;
	reg       sda_d;
	reg       sda_dd;
	reg [2:0] i2c_st;
	reg [1:0] phase;
	reg [3:0] bit_cnt;
	reg [7:0] i2c_sr;
	reg       rd_dir;
	reg       sda_drive;
	reg       i2c_wr;
	reg [7:0] i2c_wdata;

	wire scl_rise = s_scl && !scl_d;
	wire scl_fall = !s_scl && scl_d;
	// Sda edge taken a cycle late: sda moving a cycle before scl falls cannot fake start or stop
	wire i2c_start = s_scl && scl_d && !sda_d && sda_dd;
	wire i2c_stop  = s_scl && scl_d && sda_d && !sda_dd;
	wire addr_hit  = i2c_sr[7:1] == {`DMCP_SLV_ADDR_HI, s_adr};

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_d          <= 1'b1;
			sda_d          <= 1'b1;
			sda_dd         <= 1'b1;
			i2c_st         <= ST_IDLE;
			phase          <= PH_ADDR;
			bit_cnt        <= 4'h0;
			i2c_sr         <= 8'h00;
			rd_dir         <= 1'b0;
			sda_drive      <= 1'b0;
			i2c_wr         <= 1'b0;
			i2c_wdata      <= 8'h00;
			reg_rd_index_o <= 7'h00;
		end else begin
			scl_d  <= s_scl;
			sda_d  <= s_sda;
			sda_dd <= sda_d;
			i2c_wr <= 1'b0;
			if (!i2c_mode || i2c_stop) begin
				i2c_st    <= ST_IDLE;
				sda_drive <= 1'b0;
			end else if (i2c_start) begin
				i2c_st    <= ST_RX;
				phase     <= PH_ADDR;
				bit_cnt   <= 4'h0;
				sda_drive <= 1'b0;
			end else begin
				case (i2c_st)
				ST_RX: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						i2c_sr  <= {i2c_sr[6:0], s_sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						case (phase)
						PH_ADDR: begin
							if (addr_hit) begin
								rd_dir    <= i2c_sr[0];
								sda_drive <= 1'b1;
								i2c_st    <= ST_ACK;
							end else
								i2c_st <= ST_IDLE;
						end
						PH_REG: begin
							reg_rd_index_o <= i2c_sr[6:0];
							sda_drive      <= 1'b1;
							i2c_st         <= ST_ACK;
						end
						PH_DATA: begin
							i2c_wdata <= i2c_sr;
							i2c_wr    <= index_defined(reg_rd_index_o);
							sda_drive <= 1'b1;
							i2c_st    <= ST_ACK;
						end
						default: i2c_st <= ST_IDLE;
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (phase == PH_ADDR && rd_dir) begin
							i2c_sr    <= reg_rd_data_i;
							sda_drive <= !reg_rd_data_i[7];
							bit_cnt   <= 4'h1;
							i2c_st    <= ST_TX;
						end else if (phase == PH_DATA) begin
							sda_drive <= 1'b0;
							i2c_st    <= ST_IDLE;
						end else begin
							sda_drive <= 1'b0;
							phase     <= phase + 2'h1;
							i2c_st    <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							sda_drive <= 1'b0;
							i2c_st    <= ST_MACK;
						end else begin
							sda_drive <= !i2c_sr[3'h7 - bit_cnt[2:0]];
							bit_cnt   <= bit_cnt + 4'h1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise)
						i2c_st <= ST_IDLE;
				end
				default: begin
					sda_drive <= 1'b0;
					i2c_st    <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Open-drain data pin
	// ----------------------------------------
	reg sda_release;

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			sda_release <= 1'b1;
		else
			sda_release <= !sda_drive;
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_release;

	// ----------------------------------------
	// Register write output
	// ----------------------------------------
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_wr_o       <= 1'b0;
			reg_wr_index_o <= 7'h00;
			reg_wr_data_o  <= 8'h00;
		end else begin
			reg_wr_o <= spi_wr || i2c_wr;
			if (spi_wr) begin
				reg_wr_index_o <= spi_sr[14:8];
				reg_wr_data_o  <= spi_sr[7:0];
			end else if (i2c_wr) begin
				reg_wr_index_o <= reg_rd_index_o;
				reg_wr_data_o  <= i2c_wdata;
			end
		end
	end

endmodule // dmcp_mode_ctl
`default_nettype wire
